// >>> core/sdadc_pkg.sv
// Purpose: Shared constants for the sigma-delta converter register block
// Assumes: Avalon-MM byte addresses, 32-bit data words
// Notes: Register offsets are word aligned
package sdadc_pkg;
   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [4:0] SDADC_OFS_CHAN_CTRL = 5'h00;
   localparam logic [4:0] SDADC_OFS_INPUT_CONTROL = 5'h04;
   localparam logic [4:0] SDADC_OFS_CONV_RESULT = 5'h08;
   localparam logic [4:0] SDADC_OFS_PIN_ENABLE = 5'h0c;
   localparam logic [4:0] SDADC_OFS_IRQ_VECTOR = 5'h10;
   // ------------------------------------------------------------
   // Channel control field positions
   // ------------------------------------------------------------
   localparam int SDADC_BIT_RESERVED0 = 0;
   localparam int SDADC_BIT_CONV_TRIGGER = 1;
   localparam int SDADC_BIT_DONE_FLAG = 2;
   localparam int SDADC_BIT_OVERFLOW_FLAG = 5;
   localparam int SDADC_BIT_LOW_HALF = 6;
   // ------------------------------------------------------------
   // Input control field positions
   // ------------------------------------------------------------
   localparam int SDADC_POS_PAIR_LO = 0;
   localparam int SDADC_POS_GAIN_LO = 3;
   localparam int SDADC_POS_DELAY_LO = 6;
   // ------------------------------------------------------------
   // Reset values and vector codes
   // ------------------------------------------------------------
   localparam logic [7:0] SDADC_RST_INPUT_CONTROL = 8'h00;
   localparam logic [7:0] SDADC_RST_PIN_ENABLE = 8'h00;
   localparam logic [15:0] SDADC_VEC_NONE = 16'h0000;
   localparam logic [15:0] SDADC_VEC_OVERFLOW = 16'h0002;
   localparam logic [15:0] SDADC_VEC_DONE = 16'h0004;
   // Samples skipped after start for delay code 00, minus the delay code
   localparam logic [1:0] SDADC_DELAY_MAX = 2'h3;
endpackage

// >>> core/sdadc_vec.sv
// Purpose: Priority encoder for the interrupt vector word
// Assumes: Flags are registered by the caller
// Notes: Purely combinational
`timescale 1ns/10ps
module sdadc_vec (
   input wire logic overflow_i,
   input wire logic done_i,
   output logic [15:0] vector_o
);
   // ------------------------------------------------------------
   // Overflow outranks completion
   // ------------------------------------------------------------
   // vector code table
   always_comb begin
      if (overflow_i) begin
         vector_o = sdadc_pkg::SDADC_VEC_OVERFLOW;
      end else if (done_i) begin
         vector_o = sdadc_pkg::SDADC_VEC_DONE;
      end else begin
         vector_o = sdadc_pkg::SDADC_VEC_NONE;
      end
   end
endmodule // sdadc_vec

// >>> core/sdadc_regs.sv
// Purpose: Control and result registers of a sigma-delta converter
// Assumes: Filter samples arrive as one-cycle strobes on clk_sys_i
// Notes: Avalon-MM slave, one wait cycle on every access
`timescale 1ns/10ps
module sdadc_regs #(
   parameter int FILT_W = 24
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [FILT_W-1:0] filt_data_i,
   input wire logic filt_valid_i,
   output logic conv_run_o,
   output logic [2:0] preamp_gain_code_o,
   output logic [2:0] input_pair_select_o,
   output logic [7:0] pin_enable_o,
   output logic [7:0] neg_to_gnd_o
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic wait_b;
      logic [31:0] rdata;
      logic conv_trigger;
      logic low_half_access;
      logic done_flag;
      logic overflow_flag;
      logic [7:0] input_control;
      logic [7:0] pin_enable;
      logic [FILT_W-1:0] result_word;
      logic [1:0] skip_cnt;
      logic [7:0] neg_gnd;
   } sdadc_state_t;

   sdadc_state_t st_reg;
   sdadc_state_t st_next;
   logic [15:0] vec_code;
   logic access;
   logic wr_hit;
   logic rd_hit;
   logic [15:0] result_half;
   logic done_set;
   logic done_clr;

   // ------------------------------------------------------------
   // Vector encoder
   // ------------------------------------------------------------
   sdadc_vec u_vec (
      .overflow_i(st_reg.overflow_flag),
      .done_i(st_reg.done_flag),
      .vector_o(vec_code)
   );

   // Access completes on the cycle that waitrequest is low
   assign access = (avs_read_i | avs_write_i) & ~st_reg.wait_b;
   assign wr_hit = access & avs_write_i;
   assign rd_hit = access & avs_read_i;

   assign result_half = st_reg.low_half_access ? st_reg.result_word[15:0]
                                               : st_reg.result_word[FILT_W-1 -: 16];

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      done_set = 1'b0;
      done_clr = 1'b0;
      // One wait cycle, then one ready cycle
      st_next.wait_b = ~((avs_read_i | avs_write_i) & st_reg.wait_b);

      // Read data captured while waitrequest is still high
      if (avs_read_i & st_reg.wait_b) begin
         st_next.rdata = 32'h0000_0000;
         case (avs_address_i)
            sdadc_pkg::SDADC_OFS_CHAN_CTRL: begin
               st_next.rdata[sdadc_pkg::SDADC_BIT_RESERVED0] = 1'b0;
               st_next.rdata[sdadc_pkg::SDADC_BIT_CONV_TRIGGER] = st_reg.conv_trigger;
               st_next.rdata[sdadc_pkg::SDADC_BIT_DONE_FLAG] = st_reg.done_flag;
               st_next.rdata[sdadc_pkg::SDADC_BIT_OVERFLOW_FLAG] = st_reg.overflow_flag;
               st_next.rdata[sdadc_pkg::SDADC_BIT_LOW_HALF] = st_reg.low_half_access;
            end
            sdadc_pkg::SDADC_OFS_INPUT_CONTROL: begin
               st_next.rdata[7:0] = st_reg.input_control;
            end
            sdadc_pkg::SDADC_OFS_CONV_RESULT: begin
               st_next.rdata[15:0] = result_half;
            end
            sdadc_pkg::SDADC_OFS_PIN_ENABLE: begin
               st_next.rdata[7:0] = st_reg.pin_enable;
            end
            sdadc_pkg::SDADC_OFS_IRQ_VECTOR: begin
               st_next.rdata[15:0] = vec_code;
            end
            default: begin
               st_next.rdata = 32'h0000_0000;
            end
         endcase
      end

      // Register writes, low byte lane only carries fields
      if (wr_hit & avs_byteenable_i[0]) begin
         case (avs_address_i)
            sdadc_pkg::SDADC_OFS_CHAN_CTRL: begin
               st_next.conv_trigger = avs_writedata_i[sdadc_pkg::SDADC_BIT_CONV_TRIGGER];
               st_next.low_half_access = avs_writedata_i[sdadc_pkg::SDADC_BIT_LOW_HALF];
               // Flags cleared by software writing zero; done also cleared by a result read
               done_clr = ~avs_writedata_i[sdadc_pkg::SDADC_BIT_DONE_FLAG];
               if (~avs_writedata_i[sdadc_pkg::SDADC_BIT_OVERFLOW_FLAG]) begin
                  st_next.overflow_flag = 1'b0;
               end
               if (avs_writedata_i[sdadc_pkg::SDADC_BIT_CONV_TRIGGER] & ~st_reg.conv_trigger) begin
                  st_next.skip_cnt = sdadc_pkg::SDADC_DELAY_MAX -
                     st_reg.input_control[sdadc_pkg::SDADC_POS_DELAY_LO +: 2];
               end
            end
            sdadc_pkg::SDADC_OFS_INPUT_CONTROL: begin
               st_next.input_control = avs_writedata_i[7:0];
            end
            sdadc_pkg::SDADC_OFS_PIN_ENABLE: begin
               st_next.pin_enable = avs_writedata_i[7:0];
            end
            default: begin
               st_next.input_control = st_next.input_control;
            end
         endcase
      end

      // Reading the result acknowledges completion
      if (rd_hit && avs_address_i == sdadc_pkg::SDADC_OFS_CONV_RESULT) begin
         done_clr = 1'b1;
      end

      if (filt_valid_i & st_reg.conv_trigger) begin
         st_next.result_word = filt_data_i;
         if (st_reg.skip_cnt != 2'h0) begin
            st_next.skip_cnt = st_reg.skip_cnt - 2'h1;
         end else begin
            done_set = 1'b1;
            // Unread previous result is lost
            if (st_reg.done_flag) begin
               st_next.overflow_flag = 1'b1;
            end
         end
      end

      // Set wins over a same-cycle clear
      if (done_set) begin
         st_next.done_flag = 1'b1;
      end else if (done_clr) begin
         st_next.done_flag = 1'b0;
      end

      st_next.neg_gnd = ~st_next.pin_enable;
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg <= '0;
         st_reg.wait_b <= 1'b1;
         st_reg.input_control <= sdadc_pkg::SDADC_RST_INPUT_CONTROL;
         st_reg.pin_enable <= sdadc_pkg::SDADC_RST_PIN_ENABLE;
         st_reg.neg_gnd <= ~sdadc_pkg::SDADC_RST_PIN_ENABLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs straight from flip-flops
   // ------------------------------------------------------------
   assign avs_readdata_o = st_reg.rdata;
   assign avs_waitrequest_o = st_reg.wait_b;
   assign conv_run_o = st_reg.conv_trigger;
   // gain and pair to front end
   assign preamp_gain_code_o = st_reg.input_control[sdadc_pkg::SDADC_POS_GAIN_LO +: 3];
   assign input_pair_select_o = st_reg.input_control[sdadc_pkg::SDADC_POS_PAIR_LO +: 3];
   assign pin_enable_o = st_reg.pin_enable;
   assign neg_to_gnd_o = st_reg.neg_gnd;
endmodule // sdadc_regs

// >>> verif/sdadc_props.sv
// Purpose: Port checks for sdadc_regs
// Assumes: Bound from the bench top
// Notes: Sees design ports only
`timescale 1ns/10ps
module sdadc_props #(
   parameter int FILT_W = 24
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic conv_run_o,
   input wire logic [2:0] preamp_gain_code_o,
   input wire logic [2:0] input_pair_select_o,
   input wire logic [7:0] pin_enable_o,
   input wire logic [7:0] neg_to_gnd_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   logic wr_ok;
   logic rd_ok;
   // Accepted write with byte lane 0 enabled, or any accepted read, at this edge
   assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
   assign rd_ok = avs_read_i && !avs_waitrequest_o;
   AST_ONE_WAIT: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("wait cycle wrong");
   AST_TRIG_WR: assert property (wr_ok && avs_address_i == 5'h00
      |=> conv_run_o == $past(avs_writedata_i[1])) else $error("trigger bit wrong");
   AST_RUN_HOLD: assert property (!(wr_ok && avs_address_i == 5'h00)
      |=> $stable(conv_run_o)) else $error("run changed alone");
   AST_INCTL_WR: assert property (wr_ok && avs_address_i == 5'h04
      |=> {preamp_gain_code_o, input_pair_select_o} == $past(avs_writedata_i[5:0]))
      else $error("input fields wrong");
   AST_PIN_WR: assert property (wr_ok && avs_address_i == 5'h0c
      |=> pin_enable_o == $past(avs_writedata_i[7:0])) else $error("pin enable wrong");
   AST_NEG_GND: assert property (neg_to_gnd_o == ~pin_enable_o)
      else $error("ground tie wrong");
   AST_VEC_CODE: assert property (rd_ok && avs_address_i == 5'h10
      |-> avs_readdata_o inside {32'h0, 32'h2, 32'h4}) else $error("vector code wrong");
   AST_RES_UPPER: assert property (rd_ok && avs_address_i == 5'h08
      |-> avs_readdata_o[31:16] == 16'h0) else $error("result upper bits set");
   AST_CH_RSV: assert property (rd_ok && avs_address_i == 5'h00
      |-> !avs_readdata_o[0] && avs_readdata_o[1] == conv_run_o) else $error("bit 0 set");
   // Main scenarios reached
   COV_START: cover property (wr_ok && avs_address_i == 5'h00 && avs_writedata_i[1]);
   COV_OVF: cover property (rd_ok && avs_address_i == 5'h10 && avs_readdata_o == 32'h2);
   COV_RES: cover property (rd_ok && avs_address_i == 5'h08);
endmodule // sdadc_props

// >>> verif/sdadc_filt_model.sv
// Purpose: Filter stand-in giving sample strobes
// Assumes: Bench asks for each sample
// Notes: Data toggles between samples
`timescale 1ns/10ps
module sdadc_filt_model (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic fire_i,
   input wire logic [23:0] value_i,
   output logic [23:0] filt_data_o,
   output logic filt_valid_o
);
   // Inverted data off the strobe so stale values never match
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         filt_valid_o <= 1'b0;
         filt_data_o <= 24'h0;
      end else begin
         filt_valid_o <= fire_i;
         filt_data_o <= fire_i ? value_i : ~filt_data_o;
      end
   end
endmodule // sdadc_filt_model

// >>> verif/tb_sdadc_regs.sv
// Purpose: Self-checking bench for sdadc_regs
// Assumes: One wait cycle per access
// Notes: Read results checked from a queue
`timescale 1ns/10ps
module tb_sdadc_regs;
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [4:0] adr = 5'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [3:0] be = 4'h1;
   logic [31:0] rdat;
   logic wt;
   logic [23:0] fd;
   logic fv;
   logic fire = 1'b0;
   logic [23:0] fin = 24'h0;
   logic run;
   logic [2:0] gain;
   logic [2:0] pair;
   logic [7:0] pen;
   logic [7:0] neg;
   logic [31:0] exp_q[$];
   int err_total = 0;
   int samples_checked = 0;
   int seed = 67;
   always #5 clk_sys_i = ~clk_sys_i;
   sdadc_regs dut_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .filt_data_i(fd), .filt_valid_i(fv),
      .conv_run_o(run), .preamp_gain_code_o(gain), .input_pair_select_o(pair),
      .pin_enable_o(pen), .neg_to_gnd_o(neg));
   sdadc_filt_model filt_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .fire_i(fire),
      .value_i(fin), .filt_data_o(fd), .filt_valid_o(fv));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Hold request until waitrequest low, then let one edge pass
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk_sys_i);
      while (wt !== 1'b0 && n < 50) begin
         n++;
         @(posedge clk_sys_i);
      end
      if (n == 50) err_total++;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic rdc(input logic [4:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic smp(input logic [23:0] v);
      @(posedge clk_sys_i);
      fire <= 1'b1;
      fin <= v;
      @(posedge clk_sys_i);
      fire <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Read data taken at the accepting edge
   always @(posedge clk_sys_i) begin
      if (rd === 1'b1 && wt === 1'b0) chk("readdata", exp_q.pop_front(), rdat);
   end
   initial begin
      logic [7:0] r;
      logic [23:0] v;
      repeat (20) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      rdc(5'h04, 32'h0);
      rdc(5'h0c, 32'h0);
      rdc(5'h10, 32'h0);
      rdc(5'h14, 32'h0);
      chk("neg", 32'hff, {24'h0, neg});
      repeat (3) begin
         r = $random(seed);
         bus(1'b1, 5'h0c, {24'h0, r});
         rdc(5'h0c, {24'h0, r});
         chk("neg", {24'h0, ~r}, {24'h0, neg});
      end
      // Write with lane 0 disabled must leave the pin enables alone
      be <= 4'he;
      bus(1'b1, 5'h0c, {24'h0, ~r});
      be <= 4'h1;
      rdc(5'h0c, {24'h0, r});
      chk("neg", {24'h0, ~r}, {24'h0, neg});
      for (int d = 0; d < 4; d++) begin
         r = $random(seed);
         r[7:6] = d[1:0];
         bus(1'b1, 5'h04, {24'h0, r});
         rdc(5'h04, {24'h0, r});
         chk("gain_pair", {26'h0, r[5:0]}, {26'h0, gain, pair});
         bus(1'b1, 5'h00, 32'h2);
         chk("run", 32'h1, {31'h0, run});
         for (int k = 0; k < 4 - d; k++) begin
            rdc(5'h10, 32'h0);
            v = $random(seed);
            smp(v);
         end
         rdc(5'h10, 32'h4);
         v = $random(seed);
         smp(v);
         bus(1'b1, 5'h10, 32'h0);
         bus(1'b1, 5'h08, 32'h0);
         rdc(5'h10, 32'h2);
         rdc(5'h00, 32'h26);
         rdc(5'h08, {16'h0, v[23:8]});
         bus(1'b1, 5'h00, 32'h42);
         rdc(5'h08, {16'h0, v[15:0]});
         bus(1'b1, 5'h00, 32'h0);
         smp(v);
         rdc(5'h10, 32'h0);
      end
      tally_and_finish();
   end
   initial begin
      #100000;
      err_total++;
      tally_and_finish();
   end
endmodule // tb_sdadc_regs
bind sdadc_regs sdadc_props #(.FILT_W(FILT_W)) props_u (.clk_sys_i(clk_sys_i),
   .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .conv_run_o(conv_run_o),
   .preamp_gain_code_o(preamp_gain_code_o), .input_pair_select_o(input_pair_select_o),
   .pin_enable_o(pin_enable_o), .neg_to_gnd_o(neg_to_gnd_o));
